// *** design/card_config_registers.sv ***
// card configuration register bank with pin control
`timescale 1ns/1ps
`default_nettype none

module card_config_registers (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host socket pins
	input wire logic card_enable_n,
	input wire logic attr_select_n,
	input wire logic io_cycle_n,
	input wire logic read_enable_n,
	input wire logic write_enable_n,
	input wire logic [10:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// card pins driven back
	output logic status_change_pin_n,
	output logic interrupt_request_pin_n,
	// card core state
	input wire logic ready_busy_live,
	input wire logic write_protect_live,
	input wire logic interrupt_live,
	input wire logic interrupt_disable,
	// card core controls
	output logic card_reset,
	output logic power_down,
	output logic level_interrupt_select,
	output logic [5:0] mode_index,
	output logic narrow_io_only,
	output logic copy_number,
	output logic disk_mode,
	output logic taskfile_select
);

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic reg_hit(input logic [10:0] a, input logic [10:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	function automatic logic tf_hit(input logic [5:0] idx, input logic [10:0] a,
			input logic attr_n, input logic io_n);
		logic [5:0] page;
		page = a[9:4];
		case (idx)
			card_config_pkg::IDX_MEMORY: begin
				// low page 0h-Fh or the upper half 400h-7FFh only
				tf_hit = attr_n & io_n & (a[10] | ~|page);
			end
			card_config_pkg::IDX_CONTIG_IO: begin
				tf_hit = ~io_n;
			end
			card_config_pkg::IDX_PRIMARY_IO: begin
				tf_hit = ~io_n & ((page == card_config_pkg::PAGE_PRIMARY & ~a[3])
					| (page == card_config_pkg::PAGE_PRIMARY_ALT & a[3:1] == card_config_pkg::ALT_WORD));
			end
			card_config_pkg::IDX_SECONDARY_IO: begin
				tf_hit = ~io_n & ((page == card_config_pkg::PAGE_SECONDARY & ~a[3])
					| (page == card_config_pkg::PAGE_SECONDARY_ALT & a[3:1] == card_config_pkg::ALT_WORD));
			end
			default: begin
				tf_hit = 1'b0;
			end
		endcase
	endfunction

	// ************************************************************
	// disk-interface strap
	// ************************************************************
	logic strap_done_q;
	logic disk_mode_q;

	// strap sampled on the first edge after release, never under reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strap_done_q <= 1'b0;
			disk_mode_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			disk_mode_q <= ~read_enable_n;
		end
	end

	// ************************************************************
	// access strobes
	// ************************************************************
	logic we_n_q;
	logic cfg_sel;
	logic wr_stb;
	logic wr_opt, wr_cfg, wr_pin, wr_sock;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			we_n_q <= 1'b1;
		end else begin
			we_n_q <= write_enable_n;
		end
	end

	// no access until the strap is known, so disk mode never leaks a write
	assign cfg_sel = strap_done_q & ~disk_mode_q & ~card_enable_n
		& ~attr_select_n & io_cycle_n & ~addr[0];
	assign wr_stb = cfg_sel & ~write_enable_n & we_n_q;
	assign wr_opt = wr_stb & reg_hit(addr, card_config_pkg::OFS_OPTION);
	assign wr_cfg = wr_stb & reg_hit(addr, card_config_pkg::OFS_CONFIG_STATE);
	assign wr_pin = wr_stb & reg_hit(addr, card_config_pkg::OFS_PIN_MIRROR);
	assign wr_sock = wr_stb & reg_hit(addr, card_config_pkg::OFS_SOCKET_COPY);

	// ************************************************************
	// option register
	// ************************************************************
	logic soft_reset_bit_q;
	logic level_irq_q;
	logic [5:0] index_q;
	logic io_mode;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			soft_reset_bit_q <= card_config_pkg::RST_OPTION[card_config_pkg::BIT_SOFT_RESET];
			level_irq_q <= card_config_pkg::RST_OPTION[card_config_pkg::BIT_LEVEL_IRQ];
			index_q <= card_config_pkg::RST_OPTION[5:0];
		end else if (wr_opt) begin
			soft_reset_bit_q <= data_in[card_config_pkg::BIT_SOFT_RESET];
			if (data_in[card_config_pkg::BIT_SOFT_RESET]) begin
				level_irq_q <= 1'b0;
				index_q <= card_config_pkg::IDX_MEMORY;
			end else begin
				level_irq_q <= data_in[card_config_pkg::BIT_LEVEL_IRQ];
				index_q <= data_in[5:0];
			end
		end
	end

	assign io_mode = ~disk_mode_q & (index_q != card_config_pkg::IDX_MEMORY);

	// ************************************************************
	// configuration and status register
	// ************************************************************
	logic status_change_pin_en_q;
	logic narrow_q;
	logic pwd_q;
	logic irq_pending;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status_change_pin_en_q <= 1'b0;
			narrow_q <= 1'b0;
			pwd_q <= 1'b0;
		end else if (soft_reset_bit_q) begin
			status_change_pin_en_q <= 1'b0;
			narrow_q <= 1'b0;
			pwd_q <= 1'b0;
		end else if (wr_cfg) begin
			status_change_pin_en_q <= data_in[card_config_pkg::BIT_STATUS_CHANGE_PIN_EN];
			narrow_q <= data_in[card_config_pkg::BIT_NARROW_IO];
			pwd_q <= data_in[card_config_pkg::BIT_POWER_DOWN];
		end
	end

	assign irq_pending = interrupt_live & ~interrupt_disable;

	// ************************************************************
	// pin replacement latches
	// ************************************************************
	logic rdy_prev_q, wp_prev_q;
	logic rdy_chg_q, wp_chg_q;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdy_prev_q <= 1'b0;
			wp_prev_q <= 1'b0;
		end else begin
			rdy_prev_q <= ready_busy_live;
			wp_prev_q <= write_protect_live;
		end
	end

	// a change in the write cycle wins over the host value
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdy_chg_q <= card_config_pkg::RST_PIN_MIRROR[card_config_pkg::BIT_RDY_CHANGE];
			wp_chg_q <= card_config_pkg::RST_PIN_MIRROR[card_config_pkg::BIT_WP_CHANGE];
		end else begin
			if (strap_done_q & (ready_busy_live != rdy_prev_q)) begin
				rdy_chg_q <= 1'b1;
			end else if (wr_pin) begin
				rdy_chg_q <= data_in[card_config_pkg::BIT_RDY_CHANGE];
			end
			if (strap_done_q & (write_protect_live != wp_prev_q)) begin
				wp_chg_q <= 1'b1;
			end else if (wr_pin) begin
				wp_chg_q <= data_in[card_config_pkg::BIT_WP_CHANGE];
			end
		end
	end

	// ************************************************************
	// socket and copy register
	// ************************************************************
	logic copy_q;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			copy_q <= card_config_pkg::RST_SOCKET_COPY[card_config_pkg::BIT_COPY];
		end else if (wr_sock) begin
			copy_q <= data_in[card_config_pkg::BIT_COPY];
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (reg_hit(addr, card_config_pkg::OFS_OPTION)) begin
			rd_mux = {soft_reset_bit_q, level_irq_q, index_q};
		end else if (reg_hit(addr, card_config_pkg::OFS_CONFIG_STATE)) begin
			rd_mux[card_config_pkg::BIT_CHANGED] = rdy_chg_q;
			rd_mux[card_config_pkg::BIT_STATUS_CHANGE_PIN_EN] = status_change_pin_en_q;
			rd_mux[card_config_pkg::BIT_NARROW_IO] = narrow_q;
			rd_mux[card_config_pkg::BIT_POWER_DOWN] = pwd_q;
			rd_mux[card_config_pkg::BIT_IRQ_PENDING] = irq_pending;
		end else if (reg_hit(addr, card_config_pkg::OFS_PIN_MIRROR)) begin
			rd_mux = card_config_pkg::PIN_MIRROR_ONES;
			rd_mux[card_config_pkg::BIT_RDY_CHANGE] = rdy_chg_q;
			rd_mux[card_config_pkg::BIT_WP_CHANGE] = wp_chg_q;
			rd_mux[card_config_pkg::BIT_RDY_STATE] = ready_busy_live;
			rd_mux[card_config_pkg::BIT_WP_STATE] = write_protect_live;
		end else if (reg_hit(addr, card_config_pkg::OFS_SOCKET_COPY)) begin
			rd_mux[card_config_pkg::BIT_COPY] = copy_q;
		end
	end

	// unmapped even attribute addresses read as zero but still drive the bus
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end else begin
			data_oe <= cfg_sel & ~read_enable_n;
			data_out <= (cfg_sel & ~read_enable_n) ? rd_mux : 8'h00;
		end
	end

	// ************************************************************
	// interrupt request pin
	// ************************************************************
	logic pend_prev_q;
	logic [7:0] pulse_cnt_q;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pend_prev_q <= 1'b0;
			pulse_cnt_q <= 8'h00;
		end else begin
			pend_prev_q <= irq_pending;
			if (irq_pending & ~pend_prev_q) begin
				pulse_cnt_q <= card_config_pkg::IRQ_PULSE_LEN;
			end else if (pulse_cnt_q != 8'h00) begin
				pulse_cnt_q <= pulse_cnt_q - 8'h01;
			end
		end
	end

	// memory mode: pin carries ready/busy; I/O mode: interrupt request
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			interrupt_request_pin_n <= 1'b1;
		end else if (!io_mode) begin
			interrupt_request_pin_n <= ready_busy_live;
		end else if (level_irq_q) begin
			interrupt_request_pin_n <= ~irq_pending;
		end else begin
			interrupt_request_pin_n <= (pulse_cnt_q == 8'h00);
		end
	end

	// ************************************************************
	// status change pin
	// ************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status_change_pin_n <= 1'b1;
		end else begin
			status_change_pin_n <= ~(io_mode & status_change_pin_en_q & rdy_chg_q);
		end
	end

	// ************************************************************
	// core control outputs
	// ************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			card_reset <= 1'b1;
			power_down <= 1'b0;
			level_interrupt_select <= 1'b0;
			mode_index <= card_config_pkg::IDX_MEMORY;
			narrow_io_only <= 1'b0;
			copy_number <= 1'b0;
			disk_mode <= 1'b0;
			taskfile_select <= 1'b0;
		end else begin
			card_reset <= soft_reset_bit_q;
			power_down <= pwd_q;
			level_interrupt_select <= level_irq_q;
			mode_index <= index_q;
			narrow_io_only <= narrow_q;
			copy_number <= copy_q;
			disk_mode <= disk_mode_q;
			if (disk_mode_q) begin
				taskfile_select <= ~card_enable_n;
			end else begin
				taskfile_select <= ~card_enable_n & tf_hit(index_q, addr, attr_select_n, io_cycle_n);
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	disk_blocks_access_a: assert property (disk_mode_q |-> ##1 !data_oe)
		else $error("register read answered in disk mode");
	soft_reset_hold_a: assert property (soft_reset_bit_q && !wr_opt |=> soft_reset_bit_q)
		else $error("soft reset bit cleared itself");
	level_pin_a: assert property (io_mode && level_irq_q && irq_pending |=> !interrupt_request_pin_n)
		else $error("level interrupt not driven");
	index_zero_a: assert property (wr_opt && data_in[7] |=> index_q == 6'h00 ##1 mode_index == 6'h00)
		else $error("mode select not zeroed by soft reset");
	changed_pin_a: assert property (io_mode && status_change_pin_en_q && rdy_chg_q |=> !status_change_pin_n)
		else $error("status change pin not asserted");
	status_change_pin_off_a: assert property (!status_change_pin_en_q |=> status_change_pin_n)
		else $error("status change pin low while disabled");
	power_down_a: assert property (wr_cfg && !soft_reset_bit_q |=> ##1 power_down == $past(data_in[2], 2))
		else $error("power down output not following write");
	pending_mask_a: assert property (interrupt_disable |-> !rd_mux[1] || !reg_hit(addr, 11'h202))
		else $error("pending bit visible while disabled");
	ready_latch_a: assert property (strap_done_q && $changed(ready_busy_live) |=> rdy_chg_q)
		else $error("ready change not latched");
	wp_latch_a: assert property (strap_done_q && $changed(write_protect_live) |=> wp_chg_q)
		else $error("protect change not latched");
	copy_keep_a: assert property (wr_sock |=> copy_q == $past(data_in[4]) ##1 copy_number == copy_q)
		else $error("copy number not retained");

endmodule

`default_nettype wire

// *** design/card_config_pkg.sv ***
// constants for the card configuration register bank
package card_config_pkg;

	// ************************************************************
	// register byte addresses (attribute space)
	// ************************************************************
	localparam logic [10:0] OFS_OPTION = 11'h200;
	localparam logic [10:0] OFS_CONFIG_STATE = 11'h202;
	localparam logic [10:0] OFS_PIN_MIRROR = 11'h204;
	localparam logic [10:0] OFS_SOCKET_COPY = 11'h206;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_OPTION = 8'h00;
	localparam logic [7:0] RST_CONFIG_STATE = 8'h00;
	localparam logic [7:0] RST_PIN_MIRROR = 8'h0C;
	localparam logic [7:0] RST_SOCKET_COPY = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_SOFT_RESET = 7;
	localparam int BIT_LEVEL_IRQ = 6;
	localparam int BIT_CHANGED = 7;
	localparam int BIT_STATUS_CHANGE_PIN_EN = 6;
	localparam int BIT_NARROW_IO = 5;
	localparam int BIT_POWER_DOWN = 2;
	localparam int BIT_IRQ_PENDING = 1;
	localparam int BIT_RDY_CHANGE = 5;
	localparam int BIT_WP_CHANGE = 4;
	localparam int BIT_RDY_STATE = 1;
	localparam int BIT_WP_STATE = 0;
	localparam int BIT_COPY = 4;
	localparam logic [7:0] PIN_MIRROR_ONES = 8'h0C;

	// ************************************************************
	// mode select values and task-file address pages
	// ************************************************************
	localparam logic [5:0] IDX_MEMORY = 6'h00;
	localparam logic [5:0] IDX_CONTIG_IO = 6'h01;
	localparam logic [5:0] IDX_PRIMARY_IO = 6'h02;
	localparam logic [5:0] IDX_SECONDARY_IO = 6'h03;
	localparam logic [5:0] PAGE_PRIMARY = 6'h1F;
	localparam logic [5:0] PAGE_PRIMARY_ALT = 6'h3F;
	localparam logic [5:0] PAGE_SECONDARY = 6'h17;
	localparam logic [5:0] PAGE_SECONDARY_ALT = 6'h37;
	localparam logic [2:0] ALT_WORD = 3'h3;

	// ************************************************************
	// timing: pulse-mode interrupt width
	// ************************************************************
	localparam int CLOCK_MHZ = 100;
	localparam int IRQ_PULSE_NS = 100;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [7:0] IRQ_PULSE_LEN = 8'(IRQ_PULSE_CYC);

endpackage

// *** verif/host_socket_model.sv ***
// host socket controller model driving the card attribute bus
`timescale 1ns/1ps
`default_nettype none

module host_socket_model (
	// clock
	input wire logic clock,
	// socket bus towards the card
	output logic card_enable_n,
	output logic attr_select_n,
	output logic io_cycle_n,
	output logic read_enable_n,
	output logic write_enable_n,
	output logic [10:0] addr,
	output logic [7:0] data_in,
	// card answer
	input wire logic [7:0] data_out,
	input wire logic data_oe
);
	// ************************************************************
	// bus cycles
	// ************************************************************
	initial begin
		card_enable_n = 1'b1;
		attr_select_n = 1'b1;
		io_cycle_n = 1'b1;
		read_enable_n = 1'b1;
		write_enable_n = 1'b1;
		addr = 11'h000;
		data_in = 8'h00;
	end

	// released lines show inverted data so stale values never match
	task automatic release_bus(input logic [7:0] d);
		card_enable_n <= 1'b1;
		attr_select_n <= 1'b1;
		io_cycle_n <= 1'b1;
		read_enable_n <= 1'b1;
		write_enable_n <= 1'b1;
		addr <= ~addr;
		data_in <= ~d;
	endtask

	// strobe held until the edge that takes the answer, then one idle edge
	task automatic cycle(input logic wr, input logic att_n, input logic iocyc_n, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic hit);
		int n;
		@(posedge clock);
		addr <= a;
		data_in <= d;
		card_enable_n <= 1'b0;
		attr_select_n <= att_n;
		io_cycle_n <= iocyc_n;
		write_enable_n <= ~wr;
		read_enable_n <= wr;
		hit = 1'b0;
		q = 8'h00;
		n = 0;
		while (n < (wr ? 1 : 4) && hit !== 1'b1) begin
			@(posedge clock);
			hit = data_oe;
			q = data_out;
			n++;
		end
		release_bus(d);
		@(posedge clock);
	endtask

	// address presented with no strobe, for task-file decode
	task automatic probe(input logic att_n, input logic iocyc_n, input logic [10:0] a);
		@(posedge clock);
		addr <= a;
		card_enable_n <= 1'b0;
		attr_select_n <= att_n;
		io_cycle_n <= iocyc_n;
		repeat (2) @(posedge clock);
	endtask

	task automatic strap(input logic v);
		read_enable_n <= v;
	endtask
endmodule

`default_nettype wire

// *** verif/card_config_registers_tb.sv ***
// self-checking bench for the card configuration register bank
`timescale 1ns/1ps
`default_nettype none

module card_config_registers_tb;
	logic clock, nrst, card_enable_n, attr_select_n, io_cycle_n, read_enable_n, write_enable_n;
	logic [10:0] addr;
	logic [7:0] data_in, data_out, q;
	logic data_oe, status_change_pin_n, interrupt_request_pin_n, hit;
	logic ready_busy_live, write_protect_live, interrupt_live, interrupt_disable;
	logic card_reset, power_down, level_interrupt_select, narrow_io_only, copy_number, disk_mode, taskfile_select;
	logic [5:0] mode_index;
	int n_mismatch, total_checks, n;
	// {mode, attr_n, io_n, addr, expected hit}
	localparam logic [15:0] tf_tab [11] = '{
		{2'h0, 1'b1, 1'b1, 11'h005, 1'b1}, {2'h0, 1'b0, 1'b1, 11'h005, 1'b0},
		{2'h1, 1'b1, 1'b0, 11'h3A5, 1'b1}, {2'h2, 1'b1, 1'b0, 11'h1F7, 1'b1},
		{2'h2, 1'b1, 1'b0, 11'h1F8, 1'b0}, {2'h2, 1'b1, 1'b0, 11'h3F6, 1'b1},
		{2'h2, 1'b1, 1'b0, 11'h3F5, 1'b0}, {2'h3, 1'b1, 1'b0, 11'h170, 1'b1},
		{2'h3, 1'b1, 1'b0, 11'h1F0, 1'b0}, {2'h3, 1'b1, 1'b0, 11'h377, 1'b1},
		{2'h0, 1'b1, 1'b1, 11'h105, 1'b0}};

	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		ready_busy_live = 1'b1;
		write_protect_live = 1'b0;
		interrupt_live = 1'b0;
		interrupt_disable = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
	end
	always #5 clock = ~clock;

	card_config_registers card_config_registers_i (.clock(clock), .nrst(nrst), .card_enable_n(card_enable_n),
		.attr_select_n(attr_select_n), .io_cycle_n(io_cycle_n), .read_enable_n(read_enable_n),
		.write_enable_n(write_enable_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.status_change_pin_n(status_change_pin_n), .interrupt_request_pin_n(interrupt_request_pin_n),
		.ready_busy_live(ready_busy_live), .write_protect_live(write_protect_live),
		.interrupt_live(interrupt_live), .interrupt_disable(interrupt_disable), .card_reset(card_reset),
		.power_down(power_down), .level_interrupt_select(level_interrupt_select), .mode_index(mode_index),
		.narrow_io_only(narrow_io_only), .copy_number(copy_number), .disk_mode(disk_mode),
		.taskfile_select(taskfile_select));

	host_socket_model host_socket_model_i (.clock(clock), .card_enable_n(card_enable_n),
		.attr_select_n(attr_select_n), .io_cycle_n(io_cycle_n), .read_enable_n(read_enable_n),
		.write_enable_n(write_enable_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_byte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		host_socket_model_i.cycle(1'b1, 1'b0, 1'b1, a, d, q, hit);
		// outputs follow one edge after the take, so let one more pass
		@(posedge clock);
	endtask

	task automatic rd(input logic [10:0] a, input logic [7:0] exp);
		host_socket_model_i.cycle(1'b0, 1'b0, 1'b1, a, 8'h00, q, hit);
		check_bit(hit, 1'b1);
		check_byte(q, exp);
	endtask

	// core inputs change together, then settle for three edges
	task automatic core(input logic rdy, input logic wp, input logic irq, input logic dis);
		@(posedge clock);
		ready_busy_live <= rdy;
		write_protect_live <= wp;
		interrupt_live <= irq;
		interrupt_disable <= dis;
		repeat (3) @(posedge clock);
	endtask

	// read enable level held through reset and past release is the disk-mode strap, taken on the first edge after release
	task automatic do_reset(input logic strap_n);
		@(posedge clock);
		nrst <= 1'b0;
		host_socket_model_i.strap(strap_n);
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	task automatic give_verdict;
		$display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		give_verdict();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		do_reset(1'b1);
		check_bit(card_reset, 1'b0);
		rd(card_config_pkg::OFS_OPTION, card_config_pkg::RST_OPTION);
		rd(card_config_pkg::OFS_CONFIG_STATE, card_config_pkg::RST_CONFIG_STATE);
		rd(card_config_pkg::OFS_PIN_MIRROR, card_config_pkg::RST_PIN_MIRROR | 8'h02);
		rd(card_config_pkg::OFS_SOCKET_COPY, card_config_pkg::RST_SOCKET_COPY);
		rd(11'h208, 8'h00);
		wr(card_config_pkg::OFS_SOCKET_COPY, 8'hFF);
		rd(card_config_pkg::OFS_SOCKET_COPY, 8'h10);
		check_bit(copy_number, 1'b1);
		wr(card_config_pkg::OFS_OPTION, 8'h41);
		rd(card_config_pkg::OFS_OPTION, 8'h41);
		check_bit(level_interrupt_select, 1'b1);
		check_byte({2'b00, mode_index}, 8'h01);
		// writes outside attribute space or at odd bytes must be ignored
		host_socket_model_i.cycle(1'b1, 1'b0, 1'b1, 11'h201, 8'h03, q, hit);
		host_socket_model_i.cycle(1'b1, 1'b0, 1'b0, card_config_pkg::OFS_OPTION, 8'h03, q, hit);
		host_socket_model_i.cycle(1'b1, 1'b1, 1'b1, card_config_pkg::OFS_OPTION, 8'h03, q, hit);
		host_socket_model_i.cycle(1'b0, 1'b0, 1'b1, 11'h203, 8'h00, q, hit);
		check_bit(hit, 1'b0);
		rd(card_config_pkg::OFS_OPTION, 8'h41);
		wr(card_config_pkg::OFS_CONFIG_STATE, 8'h64);
		rd(card_config_pkg::OFS_CONFIG_STATE, 8'h64);
		check_bit(power_down, 1'b1);
		check_bit(narrow_io_only, 1'b1);
		wr(card_config_pkg::OFS_CONFIG_STATE, 8'h40);
		check_bit(power_down, 1'b0);
		core(1'b1, 1'b0, 1'b1, 1'b0);
		check_bit(interrupt_request_pin_n, 1'b0);
		rd(card_config_pkg::OFS_CONFIG_STATE, 8'h42);
		core(1'b1, 1'b0, 1'b1, 1'b1);
		rd(card_config_pkg::OFS_CONFIG_STATE, 8'h40);
		check_bit(interrupt_request_pin_n, 1'b1);
		core(1'b1, 1'b0, 1'b0, 1'b0);
		wr(card_config_pkg::OFS_OPTION, 8'h01);
		@(posedge clock);
		interrupt_live <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge clock);
			if (interrupt_request_pin_n === 1'b0) n++;
		end
		check_byte(8'(n), card_config_pkg::IRQ_PULSE_LEN);
		core(1'b0, 1'b0, 1'b0, 1'b0);
		check_bit(status_change_pin_n, 1'b0);
		rd(card_config_pkg::OFS_CONFIG_STATE, 8'hC0);
		rd(card_config_pkg::OFS_PIN_MIRROR, 8'h2C);
		wr(card_config_pkg::OFS_PIN_MIRROR, 8'h00);
		rd(card_config_pkg::OFS_PIN_MIRROR, 8'h0C);
		check_bit(status_change_pin_n, 1'b1);
		wr(card_config_pkg::OFS_CONFIG_STATE, 8'h00);
		core(1'b1, 1'b0, 1'b0, 1'b0);
		rd(card_config_pkg::OFS_PIN_MIRROR, 8'h2E);
		rd(card_config_pkg::OFS_CONFIG_STATE, 8'h80);
		check_bit(status_change_pin_n, 1'b1);
		core(1'b1, 1'b1, 1'b0, 1'b0);
		rd(card_config_pkg::OFS_PIN_MIRROR, 8'h3F);
		for (int i = 0; i < 11; i++) begin
			wr(card_config_pkg::OFS_OPTION, {6'h00, tf_tab[i][15:14]});
			host_socket_model_i.probe(tf_tab[i][13], tf_tab[i][12], tf_tab[i][11:1]);
			check_bit(taskfile_select, tf_tab[i][0]);
			host_socket_model_i.release_bus(8'h00);
		end
		wr(card_config_pkg::OFS_OPTION, 8'h83);
		check_bit(card_reset, 1'b1);
		rd(card_config_pkg::OFS_OPTION, 8'h80);
		repeat (20) @(posedge clock);
		check_bit(card_reset, 1'b1);
		wr(card_config_pkg::OFS_OPTION, 8'h02);
		check_bit(card_reset, 1'b0);
		do_reset(1'b0);
		check_bit(disk_mode, 1'b1);
		host_socket_model_i.cycle(1'b0, 1'b0, 1'b1, card_config_pkg::OFS_OPTION, 8'h00, q, hit);
		check_bit(hit, 1'b0);
		do_reset(1'b1);
		check_bit(disk_mode, 1'b0);
		rd(card_config_pkg::OFS_OPTION, 8'h00);
		give_verdict();
	end
endmodule

`default_nettype wire
